// ==== common/rcfp_pkg.sv ====
package rcfp_pkg;
   // -----------------------------------------------------------------
   // serial line timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ     = 100_000_000;
   localparam int BAUD_RATE  = 9600;
   // bit time rounds down to whole clock cycles
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam logic [3:0] FRAME_BITS = 4'hA;

   // -----------------------------------------------------------------
   // frame layout
   // -----------------------------------------------------------------
   localparam logic [7:0] START_BYTE = 8'h01;
   localparam int MAX_FRAME  = 41;
   localparam int OVERHEAD   = 3;
   localparam int MAX_LEN    = MAX_FRAME - OVERHEAD;
   localparam int TIM_BYTES  = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int BYTE_W     = 8;

   // first command byte
   localparam int C1_FRAME_CHECK_AUTO = 2;
   localparam int C1_FIRST_BURST      = 3;
   localparam int C1_PAUSE            = 4;
   localparam int C1_SECOND_BURST     = 5;
   localparam int C1_DATA             = 6;
   localparam int C1_EXT              = 7;
   // second command byte
   localparam int C2_WRITE_TIMING     = 0;
   localparam int C2_WIRELESS_SYNC    = 1;
   localparam int C2_WRITE_CHECK_AUTO = 2;

   typedef enum logic [3:0] {
      F_IDLE, F_SOH, F_LEN, F_CMD1, F_CMD2, F_B1, F_B2, F_TIM, F_CNT, F_DATA, F_BCC, F_DRAIN
   } rcfp_fld_t;
endpackage

// ==== design/rcfp_fifo.sv ====
`timescale 1ns/100ps
module rcfp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // drain side
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0]      count_q, count_d;
   logic [WIDTH-1:0] outData_q, outData_d;
   logic             outValid_q, outValid_d, inReady_q, inReady_d;
   logic             push, pop;

   function automatic logic [AW-1:0] incPtr(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign inReady  = inReady_q;
   assign outValid = outValid_q;
   assign outData  = outData_q;
   assign push     = inValid && inReady_q;
   assign pop      = outReady && outValid_q;

   always_comb begin
      wrPtr_d = push ? incPtr(wrPtr_q) : wrPtr_q;
      rdPtr_d = pop ? incPtr(rdPtr_q) : rdPtr_q;
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
      // a word written this cycle into the new head bypasses the array
      outData_d  = (push && wrPtr_q == rdPtr_d) ? inData : mem[rdPtr_d];
      outValid_d = count_d != '0;
      inReady_d  = count_d != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
      if (!rstn) begin
         wrPtr_q    <= '0;
         rdPtr_q    <= '0;
         count_q    <= '0;
         outData_q  <= '0;
         outValid_q <= 1'b0;
         inReady_q  <= 1'b0;
      end else begin
         wrPtr_q    <= wrPtr_d;
         rdPtr_q    <= rdPtr_d;
         count_q    <= count_d;
         outData_q  <= outData_d;
         outValid_q <= outValid_d;
         inReady_q  <= inReady_d;
      end
   end
endmodule

// ==== design/rcfp_host.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - line runs 9600 baud, 8N1
// RULE2 - frame opens with start byte 01
// RULE3 - length counts command and parameter bytes
// RULE4 - whole frame at most 41 bytes
// RULE5 - reader decodes low two bits as mode
// RULE6 - bit 2: reader computes frame check
// RULE7 - bits 2,6: reader appends two-byte check
// RULE8 - bits 2,6: host omits that check
// RULE9 - second burst forces single-command mode
// RULE10 - host keeps pause flag bit cleared
// RULE11 - second command byte only when bit 7
// RULE12 - second byte bit 1: wireless sync
// RULE13 - second byte bit 2: reader data check
// RULE14 - no second byte: defaults, sync pin
// RULE15 - command settings last one command only
// RULE16 - absent optional fields close the gap
// RULE17 - bits 3,4,5 enable one-byte durations
// RULE18 - second byte bit 0: four timings
// RULE19 - bit 6: count byte, then data
// RULE20 - check byte xors all but start
// RULE21 - reader takes flow bytes as data
// RULE22 - reader discards bad or oversize frames
module rcfp_host #(
   parameter int BIT_CYCLES = rcfp_pkg::BIT_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // command request
   input  wire logic        reqValid,
   output logic             reqReady,
   input  wire logic [7:0]  cmdMain,
   input  wire logic [7:0]  cmdExt,
   input  wire logic [7:0]  firstBurstDuration,
   input  wire logic [7:0]  secondBurstDuration,
   input  wire logic [15:0] zeroBitOffTime,
   input  wire logic [15:0] zeroBitOnTime,
   input  wire logic [15:0] oneBitOffTime,
   input  wire logic [15:0] oneBitOnTime,
   input  wire logic [7:0]  dataCount,
   // transponder data stream
   input  wire logic        dataValid,
   input  wire logic [7:0]  dataIn,
   output logic             dataReady,
   // status
   output logic             busy,
   output logic             frameDone,
   output logic             frameRejected,
   // serial line to the reader
   output logic             txd
);
   // -----------------------------------------------------------------
   // frame decoding helpers
   // -----------------------------------------------------------------
   function automatic logic fieldOn(rcfp_pkg::rcfp_fld_t f, logic [7:0] c1, logic [7:0] c2, logic [7:0] n);
      unique case (f)
         rcfp_pkg::F_CMD2: return c1[rcfp_pkg::C1_EXT];                                       // [RULE11]
         rcfp_pkg::F_B1:   return c1[rcfp_pkg::C1_FIRST_BURST];                               // [RULE17]
         rcfp_pkg::F_B2:   return c1[rcfp_pkg::C1_SECOND_BURST];                              // [RULE17]
         rcfp_pkg::F_TIM:  return c1[rcfp_pkg::C1_EXT] && c2[rcfp_pkg::C2_WRITE_TIMING];      // [RULE18]
         rcfp_pkg::F_CNT:  return c1[rcfp_pkg::C1_DATA];                                      // [RULE19]
         rcfp_pkg::F_DATA: return c1[rcfp_pkg::C1_DATA] && n != '0;                           // [RULE19]
         default:          return 1'b1;
      endcase
   endfunction

   // absent fields are skipped so later ones move forward
   function automatic rcfp_pkg::rcfp_fld_t nextField(rcfp_pkg::rcfp_fld_t f, logic [7:0] c1, logic [7:0] c2,
                                                     logic [7:0] n);
      rcfp_pkg::rcfp_fld_t g;
      logic                found;
      g     = rcfp_pkg::F_DRAIN;
      found = 1'b0;
      for (int i = int'(f) + 1; i <= int'(rcfp_pkg::F_BCC); i++) begin
         if (!found && fieldOn(rcfp_pkg::rcfp_fld_t'(i), c1, c2, n)) begin                    // [RULE16]
            g     = rcfp_pkg::rcfp_fld_t'(i);
            found = 1'b1;
         end
      end
      return g;
   endfunction

   function automatic logic [8:0] frameLen(logic [7:0] c1, logic [7:0] c2, logic [7:0] n);
      logic [8:0] l;
      l = 9'h001;
      if (c1[rcfp_pkg::C1_EXT]) l = l + 9'h001;
      if (c1[rcfp_pkg::C1_FIRST_BURST]) l = l + 9'h001;
      if (c1[rcfp_pkg::C1_SECOND_BURST]) l = l + 9'h001;
      if (c1[rcfp_pkg::C1_EXT] && c2[rcfp_pkg::C2_WRITE_TIMING]) l = l + 9'(rcfp_pkg::TIM_BYTES);
      if (c1[rcfp_pkg::C1_DATA]) l = l + 9'h001 + {1'b0, n};
      return l;                                                                               // [RULE3]
   endfunction

   // -----------------------------------------------------------------
   // data buffer
   // -----------------------------------------------------------------
   logic       fifoValid, popData;
   logic [7:0] fifoData;

   rcfp_fifo #(.WIDTH(rcfp_pkg::BYTE_W), .DEPTH(rcfp_pkg::FIFO_DEPTH)) dataBuf (
      .clk      (clk),
      .rstn     (rstn),
      .inValid  (dataValid),
      .inData   (dataIn),
      .inReady  (dataReady),
      .outValid (fifoValid),
      .outData  (fifoData),
      .outReady (popData)
   );

   // -----------------------------------------------------------------
   // frame sequencer and transmitter
   // -----------------------------------------------------------------
   rcfp_pkg::rcfp_fld_t fld_q, fld_d;
   logic [7:0]  cmd1_q, cmd1_d, cmd2_q, cmd2_d, b1_q, b1_d, b2_q, b2_d, cnt_q, cnt_d;
   logic [7:0]  len_q, len_d, idx_q, idx_d, bcc_q, bcc_d;
   logic [63:0] tim_q, tim_d;
   logic [9:0]  shift_q, shift_d;
   logic [3:0]  bitsLeft_q, bitsLeft_d;
   logic [15:0] baud_q, baud_d;
   logic        reqReady_q, reqReady_d, busy_q, busy_d, done_q, done_d, rej_q, rej_d;
   logic        sending, load, txFree;
   logic [7:0]  loadVal;
   logic [8:0]  lenReq;

   assign reqReady      = reqReady_q;
   assign busy          = busy_q;
   assign frameDone     = done_q;
   assign frameRejected = rej_q;
   assign txd           = shift_q[0];
   assign txFree        = bitsLeft_q == '0;
   assign lenReq        = frameLen(cmdMain, cmdExt, dataCount);

   always_comb begin
      fld_d = fld_q;  cmd1_d = cmd1_q;  cmd2_d = cmd2_q;  b1_d = b1_q;  b2_d = b2_q;
      cnt_d = cnt_q;  len_d = len_q;  idx_d = idx_q;  bcc_d = bcc_q;  tim_d = tim_q;
      shift_d = shift_q;  bitsLeft_d = bitsLeft_q;  baud_d = baud_q;
      reqReady_d = reqReady_q;  busy_d = busy_q;  done_d = 1'b0;  rej_d = 1'b0;
      sending = 1'b0;  loadVal = '0;
      // bit timer: each bit stands BIT_CYCLES clocks, idle line is high
      if (!txFree) begin
         if (baud_q == '0) begin
            shift_d    = {1'b1, shift_q[9:1]};                                                // [RULE1]
            bitsLeft_d = bitsLeft_q - 1'b1;
            baud_d     = 16'(BIT_CYCLES - 1);
         end else begin
            baud_d = baud_q - 1'b1;
         end
      end
      unique case (fld_q)
         rcfp_pkg::F_IDLE: begin
            if (reqValid && reqReady_q) begin
               if (lenReq > 9'(rcfp_pkg::MAX_LEN)) begin
                  rej_d = 1'b1;                                                               // [RULE4]
               end else begin
                  // pause is never sent: that flag stays clear
                  cmd1_d = cmdMain & ~(8'h01 << rcfp_pkg::C1_PAUSE);                          // [RULE10]
                  cmd2_d = cmdExt;
                  b1_d   = firstBurstDuration;
                  b2_d   = secondBurstDuration;
                  tim_d  = {oneBitOnTime, oneBitOffTime, zeroBitOnTime, zeroBitOffTime};      // [RULE18]
                  cnt_d  = dataCount;
                  len_d  = lenReq[7:0];
                  idx_d  = '0;
                  fld_d  = rcfp_pkg::F_SOH;
                  busy_d = 1'b1;
                  reqReady_d = 1'b0;
               end
            end
         end
         rcfp_pkg::F_SOH:  begin sending = 1'b1; loadVal = rcfp_pkg::START_BYTE; end          // [RULE2]
         rcfp_pkg::F_LEN:  begin sending = 1'b1; loadVal = len_q; end                         // [RULE3]
         rcfp_pkg::F_CMD1: begin sending = 1'b1; loadVal = cmd1_q; end
         rcfp_pkg::F_CMD2: begin sending = 1'b1; loadVal = cmd2_q; end                        // [RULE11]
         rcfp_pkg::F_B1:   begin sending = 1'b1; loadVal = b1_q; end                          // [RULE17]
         rcfp_pkg::F_B2:   begin sending = 1'b1; loadVal = b2_q; end                          // [RULE17]
         rcfp_pkg::F_TIM:  begin sending = 1'b1; loadVal = tim_q[{idx_q[2:0], 3'b000} +: 8]; end
         rcfp_pkg::F_CNT:  begin sending = 1'b1; loadVal = cnt_q; end                         // [RULE19]
         // data bytes go out verbatim, so no transponder check is added here
         rcfp_pkg::F_DATA: begin sending = fifoValid; loadVal = fifoData; end                 // [RULE8]
         rcfp_pkg::F_BCC:  begin sending = 1'b1; loadVal = bcc_q; end                         // [RULE20]
         rcfp_pkg::F_DRAIN: begin
            // done only once the stop bit of the check byte has left
            if (txFree) begin
               fld_d      = rcfp_pkg::F_IDLE;
               busy_d     = 1'b0;
               done_d     = 1'b1;
               reqReady_d = 1'b1;
            end
         end
      endcase
      load    = sending && txFree;
      popData = load && fld_q == rcfp_pkg::F_DATA;
      if (load) begin
         shift_d    = {1'b1, loadVal, 1'b0};                                                  // [RULE1]
         bitsLeft_d = rcfp_pkg::FRAME_BITS;
         baud_d     = 16'(BIT_CYCLES - 1);
         bcc_d      = (fld_q == rcfp_pkg::F_SOH) ? '0 : bcc_q ^ loadVal;                      // [RULE20]
         if (fld_q == rcfp_pkg::F_TIM && idx_q != 8'(rcfp_pkg::TIM_BYTES - 1)) begin
            idx_d = idx_q + 1'b1;
         end else if (fld_q == rcfp_pkg::F_DATA && idx_q != cnt_q - 1'b1) begin
            idx_d = idx_q + 1'b1;
         end else begin
            idx_d = '0;
            fld_d = nextField(fld_q, cmd1_q, cmd2_q, cnt_q);                                  // [RULE16]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         fld_q <= rcfp_pkg::F_IDLE;  cmd1_q <= '0;  cmd2_q <= '0;  b1_q <= '0;  b2_q <= '0;
         cnt_q <= '0;  len_q <= '0;  idx_q <= '0;  bcc_q <= '0;  tim_q <= '0;
         shift_q <= '1;  bitsLeft_q <= '0;  baud_q <= '0;
         reqReady_q <= 1'b1;  busy_q <= 1'b0;  done_q <= 1'b0;  rej_q <= 1'b0;
      end else begin
         fld_q <= fld_d;  cmd1_q <= cmd1_d;  cmd2_q <= cmd2_d;  b1_q <= b1_d;  b2_q <= b2_d;
         cnt_q <= cnt_d;  len_q <= len_d;  idx_q <= idx_d;  bcc_q <= bcc_d;  tim_q <= tim_d;
         shift_q <= shift_d;  bitsLeft_q <= bitsLeft_d;  baud_q <= baud_d;
         reqReady_q <= reqReady_d;  busy_q <= busy_d;  done_q <= done_d;  rej_q <= rej_d;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [7:0] payCnt_q, xorAcc_q, totCnt_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         payCnt_q <= '0;
         xorAcc_q <= '0;
         totCnt_q <= '0;
      end else if (load) begin
         if (fld_q == rcfp_pkg::F_SOH) begin
            payCnt_q <= '0;
            xorAcc_q <= '0;
            totCnt_q <= 8'h01;
         end else begin
            totCnt_q <= totCnt_q + 8'h01;
            if (fld_q != rcfp_pkg::F_BCC) xorAcc_q <= xorAcc_q ^ loadVal;
            if (fld_q != rcfp_pkg::F_LEN && fld_q != rcfp_pkg::F_BCC) payCnt_q <= payCnt_q + 8'h01;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_start_first: assert property (load && $past(fld_q) == rcfp_pkg::F_IDLE |-> loadVal == rcfp_pkg::START_BYTE) // [RULE2]
      else $error("frame did not open with the start byte");
   a_len_match: assert property (load && fld_q == rcfp_pkg::F_BCC |-> payCnt_q == len_q) // [RULE3]
      else $error("length byte does not match bytes sent");
   // the count still holds the previous frame's total when the next start byte loads
   a_frame_limit: assert property (load && fld_q != rcfp_pkg::F_SOH |-> totCnt_q < 8'(rcfp_pkg::MAX_FRAME)) // [RULE4]
      else $error("frame longer than the limit");
   a_long_reject: assert property (reqValid && reqReady && lenReq > 9'(rcfp_pkg::MAX_LEN)
                                   |=> frameRejected && !busy && reqReady) // [RULE4]
      else $error("oversize request not rejected");
   a_check_value: assert property (load && fld_q == rcfp_pkg::F_BCC |-> loadVal == xorAcc_q) // [RULE20]
      else $error("check byte is not the xor of the frame");
   a_ext_gate: assert property (load && fld_q == rcfp_pkg::F_CMD2 |-> cmd1_q[rcfp_pkg::C1_EXT]) // [RULE11]
      else $error("second command byte sent without its flag");
   a_pause_clear: assert property (load && fld_q == rcfp_pkg::F_CMD1 |-> !loadVal[rcfp_pkg::C1_PAUSE]) // [RULE10]
      else $error("pause flag sent set");
   a_timing_gate: assert property (load && fld_q == rcfp_pkg::F_TIM
                                   |-> cmd1_q[rcfp_pkg::C1_EXT] && cmd2_q[rcfp_pkg::C2_WRITE_TIMING]) // [RULE18]
      else $error("write timing sent without its flag");
   a_burst_gate: assert property (load && fld_q == rcfp_pkg::F_B2 |-> cmd1_q[rcfp_pkg::C1_SECOND_BURST]) // [RULE17]
      else $error("second burst sent without its flag");
   // the start bit spans the whole first bit count, whatever the bit time
   a_start_bit: assert property (bitsLeft_q == rcfp_pkg::FRAME_BITS |-> !txd) // [RULE1]
      else $error("start bit not held low");
   a_stop_bit: assert property (bitsLeft_q == 4'h1 |-> txd && $past(shift_q[9])) // [RULE1]
      else $error("stop bit not high");

   c_ext_frame:  cover property (load && fld_q == rcfp_pkg::F_CMD2);
   c_data_frame: cover property (load && fld_q == rcfp_pkg::F_DATA && idx_q == 8'h01);
   c_rejected:   cover property (frameRejected);
   c_done:       cover property (frameDone);
endmodule

// ==== bench/rcfp_reader_model.sv ====
`timescale 1ns/100ps
module rcfp_reader_model #(
   parameter int BIT_CYCLES = 4
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // serial line from the host, wireless sync pin
   input  wire logic       rxd,
   input  wire logic       wirelessSyncPin,
   // last received frame, good or bad, and the settings decoded from the last good one
   output logic [7:0]      frameBuf [41],
   output int              frameLen,
   output int              framesGood,
   output int              framesBad,
   output logic [1:0]      runMode,
   output logic            wirelessSync,
   output logic [2:0]      checkAuto
);
   logic [7:0] rxByte;
   logic [7:0] ext;
   logic [7:0] bcc;
   int         n;

   // -----------------------------------------------------------------
   // receiver: mid-bit sampling, stop bit must be high
   // -----------------------------------------------------------------
   task automatic get_byte(output logic [7:0] v);
      do @(posedge clk); while (rxd !== 1'b0 || !rstn);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         v[i] = rxd;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      if (rxd !== 1'b1) framesBad++;
   endtask

   // -----------------------------------------------------------------
   // frame parsing
   // -----------------------------------------------------------------
   initial begin
      framesGood = 0;
      framesBad = 0;
      frameLen = 0;
      runMode = 2'h0;
      wirelessSync = 1'b0;
      checkAuto = 3'h0;
      n = 0;
      forever begin
         get_byte(rxByte);
         if (n == 0 && rxByte !== rcfp_pkg::START_BYTE) continue;
         // flow-control values are plain data here
         frameBuf[n] = rxByte;
         n++;
         if (n >= 2 && (n == frameBuf[1] + 3 || n == rcfp_pkg::MAX_FRAME)) begin
            bcc = 8'h00;
            for (int i = 1; i < n - 1; i++) bcc ^= frameBuf[i];
            if (bcc !== rxByte || n != frameBuf[1] + 3) begin
               framesBad++;
            end else begin
               // settings replaced on every good frame, never kept; a bad frame leaves them as they were
               ext = frameBuf[2][7] ? frameBuf[3] : 8'h00;
               runMode = frameBuf[2][5] ? 2'h0 : frameBuf[2][1:0];
               wirelessSync = frameBuf[2][7] ? ext[1] : wirelessSyncPin;
               checkAuto = {ext[2], frameBuf[2][2] & frameBuf[2][6], frameBuf[2][2]};
               framesGood++;
            end
            frameLen = n;
            n = 0;
         end
      end
   end
endmodule

// ==== bench/reader_command_frame_parser_bench.sv ====
`timescale 1ns/100ps
module reader_command_frame_parser_bench;
   typedef struct {
      logic [7:0] cmdMain, cmdExt, b1, b2;
      logic [63:0] tim;
      logic [7:0] cnt;
      logic [1:0] expMode;
      logic expSync;
   } rcfp_row_t;
   typedef logic [7:0] rcfp_bq_t [$];

   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        reqValid = 1'b0;
   logic [7:0]  cmdMain = 8'h00;
   logic [7:0]  cmdExt = 8'h00;
   logic [7:0]  firstBurstDuration = 8'h00;
   logic [7:0]  secondBurstDuration = 8'h00;
   logic [63:0] tim = 64'h0;
   logic [7:0]  dataCount = 8'h00;
   logic        dataValid = 1'b0;
   logic [7:0]  dataIn = 8'h00;
   logic        reqReady, dataReady, busy, frameDone, frameRejected, txd;
   logic        sawFull = 1'b0;
   logic [7:0]  frameBuf [41];
   int          frameLen, framesGood, framesBad, goodExp;
   logic [1:0]  runMode;
   logic        wirelessSync;
   logic [2:0]  checkAuto;
   int          mismatches = 0;
   int          samplesChecked = 0;
   rcfp_row_t   rows [7] = '{
      '{8'h00, 8'h00, 8'h00, 8'h00, 64'h0, 8'h00, 2'h0, 1'b1},
      '{8'h09, 8'h00, 8'h1E, 8'h00, 64'h0, 8'h00, 2'h1, 1'b1},
      '{8'h22, 8'h00, 8'h00, 8'h32, 64'h0, 8'h00, 2'h0, 1'b1},
      '{8'h13, 8'h00, 8'h00, 8'h00, 64'h0, 8'h00, 2'h3, 1'b1},
      '{8'hC6, 8'h07, 8'h00, 8'h00, 64'h1C2B_3A49_5867_7685, 8'h03, 2'h2, 1'b1},
      '{8'h80, 8'h00, 8'h00, 8'h00, 64'h0, 8'h00, 2'h0, 1'b0},
      '{8'h7C, 8'h00, 8'h0A, 8'h14, 64'h0, 8'h00, 2'h0, 1'b1}};
   rcfp_row_t   big = '{8'hC0, 8'h01, 8'h00, 8'h00, 64'hFEDC_BA98_7654_3210, 8'h1C, 2'h0, 1'b0};

   always #5 clk = ~clk;
   always @(posedge clk) if (rstn && dataValid && !dataReady) sawFull <= 1'b1;

   rcfp_host #(.BIT_CYCLES(4)) dut_u (.clk(clk), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady),
      .cmdMain(cmdMain), .cmdExt(cmdExt), .firstBurstDuration(firstBurstDuration),
      .secondBurstDuration(secondBurstDuration), .zeroBitOffTime(tim[15:0]), .zeroBitOnTime(tim[31:16]),
      .oneBitOffTime(tim[47:32]), .oneBitOnTime(tim[63:48]), .dataCount(dataCount), .dataValid(dataValid),
      .dataIn(dataIn), .dataReady(dataReady), .busy(busy), .frameDone(frameDone),
      .frameRejected(frameRejected), .txd(txd));
   rcfp_reader_model #(.BIT_CYCLES(4)) model_u (.clk(clk), .rstn(rstn), .rxd(txd), .wirelessSyncPin(1'b1),
      .frameBuf(frameBuf), .frameLen(frameLen), .framesGood(framesGood), .framesBad(framesBad),
      .runMode(runMode), .wirelessSync(wirelessSync), .checkAuto(checkAuto));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic closeOut();
      $display("checks %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic checkVal(input string what, input logic [15:0] expV, input logic [15:0] gotV);
      samplesChecked++;
      if (gotV !== expV) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, expV, gotV);
      end
   endtask

   // sel: 0 frame done, 1 request ready, 2 fifo ready; sampled at the edge
   task automatic waitFor(input int sel, input int limit);
      for (int n = 0; (sel == 0 ? frameDone : sel == 1 ? reqReady : dataReady) !== 1'b1; n++) begin
         if (n > limit) begin
            mismatches++;
            $display("CHECK FAILED wait %0d expected 1 seen timeout", sel);
            closeOut();
         end
         @(posedge clk);
      end
   endtask

   function automatic rcfp_bq_t frameOf(rcfp_row_t r);
      rcfp_bq_t q;
      logic [7:0] c1;
      logic [7:0] x;
      c1 = r.cmdMain & 8'hEF; // pause field never sent
      q = {c1};
      if (c1[7]) q.push_back(r.cmdExt);
      if (c1[3]) q.push_back(r.b1);
      if (c1[5]) q.push_back(r.b2);
      if (c1[7] && r.cmdExt[0]) for (int i = 0; i < 8; i++) q.push_back(r.tim[8*i +: 8]);
      if (c1[6]) q.push_back(r.cnt);
      if (c1[6]) for (int k = 0; k < r.cnt; k++) q.push_back(8'(8'h11 + 2 * k));
      q.push_front(8'(q.size()));
      x = 8'h00;
      foreach (q[i]) x ^= q[i];
      q.push_back(x);
      q.push_front(rcfp_pkg::START_BYTE);
      return q;
   endfunction

   // bytes 11 and 13 are the flow-control values, sent as data
   task automatic push(input int n);
      for (int k = 0; k < n; k++) begin
         dataValid <= 1'b1;
         dataIn <= 8'(8'h11 + 2 * k);
         @(posedge clk);
         waitFor(2, 5000);
      end
      dataValid <= 1'b0;
   endtask

   task automatic send(input rcfp_row_t r, input bit rej);
      rcfp_bq_t e;
      e = frameOf(r);
      cmdMain <= r.cmdMain;
      cmdExt <= r.cmdExt;
      firstBurstDuration <= r.b1;
      secondBurstDuration <= r.b2;
      tim <= r.tim;
      dataCount <= r.cnt;
      reqValid <= 1'b1;
      @(posedge clk);
      waitFor(1, 10);
      reqValid <= 1'b0;
      @(posedge clk);
      checkVal("frameRejected", 16'(rej), 16'(frameRejected));
      checkVal("busy", 16'(!rej), 16'(busy));
      if (!rej) begin
         goodExp++;
         waitFor(0, 3000);
         checkVal("busy after done", 16'h0, 16'(busy));
         checkVal("idle line", 16'h1, 16'(txd));
         checkVal("frame length", 16'(e.size()), 16'(frameLen));
         foreach (e[i]) checkVal("frame byte", 16'(e[i]), 16'(frameBuf[i]));
         checkVal("mode", 16'(r.expMode), 16'(runMode));
         checkVal("sync", 16'(r.expSync), 16'(wirelessSync));
         checkVal("check flags", 16'({r.cmdMain[7] & r.cmdExt[2], r.cmdMain[2] & r.cmdMain[6], r.cmdMain[2]}),
                  16'(checkAuto));
      end
      checkVal("good frames", 16'(goodExp), 16'(framesGood));
      checkVal("bad frames", 16'h0, 16'(framesBad));
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      goodExp = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      checkVal("reqReady", 16'h1, 16'(reqReady));
      checkVal("reset idle line", 16'h1, 16'(txd));
      checkVal("dataReady", 16'h1, 16'(dataReady));
      $display("test reset done");
      foreach (rows[t]) begin
         push(rows[t].cnt);
         send(rows[t], 1'b0);
         $display("test row %0d done", t);
      end
      send(big, 1'b1);
      $display("test oversize done");
      big.cnt = 8'h1B;
      fork
         send(big, 1'b0);
         begin
            repeat (600) @(posedge clk);
            push(27);
         end
      join
      checkVal("fifo filled", 16'h1, 16'(sawFull));
      $display("test largest frame done");
      closeOut();
   end
endmodule
